// File: include/dcs_map.svh
// Contract
// R1 - Stores write through, update on hit, never allocate.
// R2 - Three word write buffer holds stores until done.
// R3 - Byte and half stores replicated across lanes.
// R4 - Drain write buffer before any load miss fill.
// R5 - Flush starts on instruction or control request.
// R6 - Flush spends one cycle per line per set.
// R7 - During flush accesses bypass cache, no stall.
// R8 - After flush, follow current cache state field.
// R9 - Snoop DMA, target and debug writes when enabled.
// R10 - Snooped cacheable write invalidates present line.
// R11 - Snooping never stalls the load/store stage.
// R12 - Load error sets valid bit, trap 0x09.
// R13 - Store error not tied to its store.
// R14 - Buffered write error raises trap 0x2B.
// R15 - Only identifier bits three to zero decoded.
// R16 - Offset picks line, low tag bit picks set.
// R17 - Identifiers 0x0-0x3 force miss, replace if cacheable.
// R18 - Identifiers 0x4, 0x7 force miss, update on hit.
// R19 - Identifiers 0x8-0xB are normal accesses.
// R20 - 0xC instruction tags, 0xE data tags.
// R21 - 0xD instruction data, 0xF data sub-blocks.
// R22 - Diagnostic access during flush refused, trap 0x09.
// R23 - Two ways, sixteen kilobytes, four-word lines, word valids.
// R24 - Read miss fetches one word into cache.
// R25 - Frozen serves hits, allocates nothing.
// R26 - Full write buffer stalls a further store.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_TRAP_DATA_ACCESS 8'h09
`define DCS_TRAP_WRITE_ERROR 8'h2b
`define DCS_MODE_DISABLED    2'h0
`define DCS_MODE_FROZEN      2'h1
`define DCS_MODE_ENABLED     2'h3
`define DCS_ASI_FORCE_LAST   4'h3
`define DCS_ASI_UPD_A        4'h4
`define DCS_ASI_UPD_B        4'h7
`define DCS_ASI_FLUSH_IC     4'h5
`define DCS_ASI_FLUSH_DC     4'h6
`define DCS_ASI_IC_TAG       4'hc
`define DCS_ASI_IC_DATA      4'hd
`define DCS_ASI_DC_TAG       4'he
`define DCS_ASI_DC_DATA      4'hf
`define DCS_SIZE_BYTE        2'h0
`define DCS_SIZE_HALF        2'h1
`define DCS_MASTER_CPU       2'h3
`define DCS_TAG_LSB          13
`define DCS_IDX_LSB          4
`define DCS_WORD_LSB         2
`define DCS_FLUSH_LAST       10'h3ff
`endif

// File: include/dcs_pkg.sv
package dcs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_READ  = 2'b10,
    ST_ICDG  = 2'b11
  } dcs_state_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        alt;
    logic [7:0]  asi;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcs_ls_req_t;
  typedef struct packed {
    logic        ack;
    logic        trap;
    logic [7:0]  trapType;
    logic [31:0] rdata;
  } dcs_ls_rsp_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcs_mem_req_t;
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dcs_mem_rsp_t;
  typedef struct packed {
    logic        valid;
    logic [1:0]  master;
    logic [31:0] addr;
  } dcs_snoop_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        dataSel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcs_ic_diag_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } dcs_wb_entry_t;
  typedef struct packed {
    dcs_state_t         state;
    dcs_ls_rsp_t        lsRsp;
    dcs_mem_req_t       memReq;
    dcs_ic_diag_t       icReq;
    logic               icFlush;
    logic               writeErrTrap;
    logic               flushing;
    logic [9:0]         flushCnt;
    logic [1:0]         wbCount;
    dcs_wb_entry_t [2:0] wb;
  } dcs_regs_t;
endpackage

// File: rtl/dcs_data_cache.sv
`include "dcs_map.svh"

module dcs_data_cache
  import dcs_pkg::*;
#(
  parameter int WB_DEPTH = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire dcs_ls_req_t  lsReq,
  output      dcs_ls_rsp_t  lsRsp,
  input  wire logic         flushInsn,
  input  wire logic         dcacheFlushRequest,
  input  wire logic [1:0]   dcacheStateField,
  input  wire logic         snoopEnableBit,
  output      logic         flushPending,
  output      logic         writeErrTrap,
  output      dcs_mem_req_t memReq,
  input  wire dcs_mem_rsp_t memRsp,
  input  wire dcs_snoop_t   snoop,
  output      dcs_ic_diag_t icReq,
  input  wire dcs_mem_rsp_t icRsp,
  output      logic         icFlush
);
  if (WB_DEPTH < 1 || WB_DEPTH > 3) begin
    $error("WB_DEPTH must lie between 1 and 3");
  end

  // Two ways of 512 four-word lines; a valid bit per word. R23
  logic [18:0] tagArr   [2][512];
  logic [3:0]  validArr [2][512];
  logic [31:0] dataArr  [2][2048];
  logic        lruArr   [512];

  dcs_regs_t r;
  dcs_regs_t next_r;

  logic        tagWe;
  logic        tagWay;
  logic [8:0]  tagIdx;
  logic [18:0] tagWd;
  logic [3:0]  valWd;
  logic        dataWe;
  logic        dataWay;
  logic [10:0] dataIdx;
  logic [31:0] dataWd;
  logic        lruWe;
  logic        lruWd;
  logic [8:0]  lruIdx;
  logic [1:0]  snoopHit;

  function automatic logic cacheable(input logic [31:0] a);
    cacheable = (a[31:29] == 3'h0) || (a[31:30] == 2'h1);
  endfunction

  function automatic logic [31:0] replicate(input logic [1:0] sz, input logic [31:0] d);
    if (sz == `DCS_SIZE_BYTE) begin
      replicate = {4{d[7:0]}};
    end else if (sz == `DCS_SIZE_HALF) begin
      replicate = {2{d[15:0]}};
    end else begin
      replicate = d;
    end
  endfunction

  // Lane 0 is the most significant byte, as on a big-endian bus.
  function automatic logic [3:0] byteEn(input logic [1:0] sz, input logic [1:0] off);
    if (sz == `DCS_SIZE_BYTE) begin
      byteEn = 4'h8 >> off;
    end else if (sz == `DCS_SIZE_HALF) begin
      byteEn = off[1] ? 4'h3 : 4'hc;
    end else begin
      byteEn = 4'hf;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [3:0] be, input logic [31:0] nw,
                                        input logic [31:0] old);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  logic [8:0]  reqIdx;
  logic [18:0] reqTag;
  logic [1:0]  reqWord;
  logic [3:0]  asiLo;
  logic [1:0]  hitVec;
  logic        hit;
  logic        hitWay;
  logic        diagWay;
  logic        forceMiss;
  logic        updOnly;
  logic [1:0]  mode;
  logic        cacheOn;
  logic [3:0]  reqBe;
  logic [31:0] reqData;

  always_comb begin
    reqIdx  = lsReq.addr[`DCS_TAG_LSB-1:`DCS_IDX_LSB];
    reqTag  = lsReq.addr[31:`DCS_TAG_LSB];
    reqWord = lsReq.addr[`DCS_IDX_LSB-1:`DCS_WORD_LSB];
    asiLo   = lsReq.asi[3:0]; // R15
    for (int w = 0; w < 2; w++) begin
      hitVec[w] = validArr[w][reqIdx][reqWord] && (tagArr[w][reqIdx] == reqTag);
    end
    hit       = |hitVec;
    hitWay    = hitVec[1];
    diagWay   = lsReq.addr[`DCS_TAG_LSB]; // R16
    forceMiss = lsReq.alt && (asiLo <= `DCS_ASI_UPD_B) && (asiLo != `DCS_ASI_FLUSH_IC)
                && (asiLo != `DCS_ASI_FLUSH_DC); // R17 R18
    updOnly   = lsReq.alt && (asiLo == `DCS_ASI_UPD_A || asiLo == `DCS_ASI_UPD_B); // R18
    mode      = r.flushing ? `DCS_MODE_DISABLED : dcacheStateField; // R7 R8
    cacheOn   = (mode != `DCS_MODE_DISABLED);
    reqBe     = byteEn(lsReq.size, lsReq.addr[1:0]);
    reqData   = replicate(lsReq.size, lsReq.wdata); // R3
  end

  // Snoop lookup uses its own read of the tag array, so it costs no cycle. R11
  logic [8:0]  snpIdx;
  logic [18:0] snpTag;
  logic        snpWatch;
  always_comb begin
    snpIdx   = snoop.addr[`DCS_TAG_LSB-1:`DCS_IDX_LSB];
    snpTag   = snoop.addr[31:`DCS_TAG_LSB];
    snpWatch = snoopEnableBit && snoop.valid && (snoop.master != `DCS_MASTER_CPU)
               && cacheable(snoop.addr); // R9
    for (int w = 0; w < 2; w++) begin
      snoopHit[w] = snpWatch && (|validArr[w][snpIdx]) && (tagArr[w][snpIdx] == snpTag); // R10
    end
  end

  logic [1:0]  wbCnt;
  logic        fill;
  logic        fillWay;
  logic        keepOld;

  always_comb begin
    next_r              = r;
    next_r.lsRsp.ack    = 1'b0;
    next_r.lsRsp.trap   = 1'b0;
    next_r.writeErrTrap = 1'b0;
    next_r.icFlush      = 1'b0;
    tagWe   = 1'b0;
    tagWay  = 1'b0;
    tagIdx  = reqIdx;
    tagWd   = reqTag;
    valWd   = 4'h0;
    dataWe  = 1'b0;
    dataWay = 1'b0;
    dataIdx = {reqIdx, reqWord};
    dataWd  = reqData;
    lruWe   = 1'b0;
    lruWd   = 1'b0;
    lruIdx  = reqIdx;
    fill    = 1'b0;
    fillWay = 1'b0;
    keepOld = 1'b0;
    wbCnt   = r.wbCount;

    // Buffered write finished: free the head entry; an error traps whatever runs now.
    if (r.memReq.valid && r.memReq.write && memRsp.ack) begin
      next_r.memReq.valid = 1'b0;
      next_r.wb[0] = r.wb[1]; // R2
      next_r.wb[1] = r.wb[2];
      wbCnt = r.wbCount - 2'd1;
      next_r.writeErrTrap = memRsp.err; // R13 R14
    end else if (!r.memReq.valid && r.wbCount != 2'd0) begin
      next_r.memReq = '{valid: 1'b1, write: 1'b1, be: r.wb[0].be,
                        addr: r.wb[0].addr, wdata: r.wb[0].data}; // R1
    end

    // Flush clears one line of one set per cycle. R6
    if (r.flushing) begin
      tagWe  = 1'b1;
      tagWay = r.flushCnt[9];
      tagIdx = r.flushCnt[8:0];
      tagWd  = tagArr[r.flushCnt[9]][r.flushCnt[8:0]];
      // The victim pointers power up unknown, so the flush clears them as well.
      lruWe  = 1'b1;
      lruWd  = 1'b0;
      lruIdx = r.flushCnt[8:0];
      next_r.flushCnt = r.flushCnt + 10'd1;
      if (r.flushCnt == `DCS_FLUSH_LAST) begin
        next_r.flushing = 1'b0;
      end
    end else if (flushInsn || dcacheFlushRequest) begin
      next_r.flushing = 1'b1; // R5
      next_r.flushCnt = '0;
    end

    case (r.state)
      ST_IDLE: begin
        if (lsReq.valid && !r.lsRsp.ack) begin
          if (lsReq.alt && asiLo >= `DCS_ASI_IC_TAG) begin
            if (r.flushing) begin
              next_r.lsRsp = '{ack: 1'b1, trap: 1'b1, trapType: `DCS_TRAP_DATA_ACCESS,
                               rdata: 32'h0}; // R22
            end else if (asiLo == `DCS_ASI_IC_TAG || asiLo == `DCS_ASI_IC_DATA) begin
              next_r.icReq = '{valid: 1'b1, write: lsReq.write,
                               dataSel: (asiLo == `DCS_ASI_IC_DATA),
                               addr: lsReq.addr, wdata: lsReq.wdata}; // R20 R21
              next_r.state = ST_ICDG;
            end else if (asiLo == `DCS_ASI_DC_TAG) begin
              next_r.lsRsp.ack = 1'b1;
              next_r.lsRsp.rdata = {tagArr[diagWay][reqIdx], 9'h0,
                                    validArr[diagWay][reqIdx]}; // R20
              if (lsReq.write) begin
                tagWe  = 1'b1;
                tagWay = diagWay;
                tagWd  = lsReq.wdata[31:`DCS_TAG_LSB];
                valWd  = lsReq.wdata[3:0];
              end
            end else begin
              next_r.lsRsp.ack = 1'b1;
              next_r.lsRsp.rdata = dataArr[diagWay][{reqIdx, reqWord}]; // R21
              dataWe  = lsReq.write;
              dataWay = diagWay;
              dataWd  = lsReq.wdata;
            end
          end else if (lsReq.alt && asiLo == `DCS_ASI_FLUSH_DC) begin
            next_r.lsRsp.ack = 1'b1;
            if (!r.flushing) begin
              next_r.flushing = 1'b1;
              next_r.flushCnt = '0;
            end
          end else if (lsReq.alt && asiLo == `DCS_ASI_FLUSH_IC) begin
            next_r.lsRsp.ack = 1'b1;
            next_r.icFlush   = 1'b1;
          end else if (lsReq.write) begin
            // A full buffer holds the store off until the head entry retires.
            if (wbCnt != 2'(WB_DEPTH)) begin // R26
              next_r.wb[wbCnt] = '{addr: lsReq.addr, data: reqData, be: reqBe}; // R2 R3
              wbCnt = wbCnt + 2'd1;
              next_r.lsRsp.ack = 1'b1;
              if (hit && cacheOn) begin
                dataWe  = 1'b1; // R1
                dataWay = hitWay;
                dataWd  = merge(reqBe, reqData, dataArr[hitWay][{reqIdx, reqWord}]);
              end
            end
          end else if (hit && cacheOn && !forceMiss) begin
            next_r.lsRsp.ack   = 1'b1; // R19 R25
            next_r.lsRsp.rdata = dataArr[hitWay][{reqIdx, reqWord}];
            lruWe = 1'b1;
            lruWd = ~hitWay;
          end else begin
            next_r.state = ST_DRAIN; // R7 R17 R18 R19
          end
        end
      end
      ST_DRAIN: begin
        // Stale buffered stores must reach memory before the fill reads it. R4
        if (wbCnt == 2'd0 && !next_r.memReq.valid) begin
          next_r.memReq = '{valid: 1'b1, write: 1'b0, be: 4'hf,
                            addr: {lsReq.addr[31:2], 2'h0}, wdata: 32'h0}; // R24
          next_r.state = ST_READ;
        end
      end
      ST_READ: begin
        if (memRsp.ack) begin
          next_r.memReq.valid = 1'b0;
          next_r.lsRsp = '{ack: 1'b1, trap: memRsp.err, trapType: `DCS_TRAP_DATA_ACCESS,
                           rdata: memRsp.rdata}; // R12
          // Enabled allocates; frozen and update-only modes just refresh a hit.
          fill = (hit && cacheOn) || (!updOnly && mode == `DCS_MODE_ENABLED
                                      && cacheable(lsReq.addr)); // R17 R18 R25
          fillWay = hit ? hitWay : lruArr[reqIdx];
          keepOld = (tagArr[fillWay][reqIdx] == reqTag);
          if (fill) begin
            tagWe   = 1'b1; // R12 R24
            tagWay  = fillWay;
            valWd   = (keepOld ? validArr[fillWay][reqIdx] : 4'h0) | (4'h1 << reqWord);
            dataWe  = 1'b1;
            dataWay = fillWay;
            dataWd  = memRsp.rdata;
            lruWe   = 1'b1;
            lruWd   = ~fillWay;
          end
          next_r.state = ST_IDLE;
        end
      end
      ST_ICDG: begin
        if (icRsp.ack) begin
          next_r.icReq.valid = 1'b0;
          next_r.lsRsp = '{ack: 1'b1, trap: icRsp.err, trapType: `DCS_TRAP_DATA_ACCESS,
                           rdata: icRsp.rdata};
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    next_r.wbCount = wbCnt;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Reset starts a flush so the valid bits are known before first use.
      r          <= '0;
      r.flushing <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (tagWe) begin
      tagArr[tagWay][tagIdx]   <= tagWd;
      validArr[tagWay][tagIdx] <= valWd;
    end
    if (dataWe) begin
      dataArr[dataWay][dataIdx] <= dataWd;
    end
    if (lruWe) begin
      lruArr[lruIdx] <= lruWd;
    end
    // Snoop clears come last so they win over a fill of the same line.
    for (int w = 0; w < 2; w++) begin
      if (snoopHit[w]) begin
        validArr[w][snpIdx] <= 4'h0; // R10 R11
      end
    end
  end

  assign lsRsp        = r.lsRsp;
  assign memReq       = r.memReq;
  assign icReq        = r.icReq;
  assign icFlush      = r.icFlush;
  assign writeErrTrap = r.writeErrTrap;
  assign flushPending = r.flushing;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  flush_start_a: assert property ($rose(r.flushing) |-> r.flushCnt == 10'h0) // R6
    else $error("flush did not start at line zero");
  flush_end_a: assert property (r.flushing && r.flushCnt == 10'h3ff |=> !r.flushing) // R6
    else $error("flush did not end after the last line");
  wb_bound_a: assert property (r.wbCount <= 2'(WB_DEPTH)) // R2
    else $error("write buffer count above depth");
  store_stall_a: assert property (r.state == ST_IDLE && lsReq.valid && lsReq.write
      && !lsReq.alt && !r.lsRsp.ack && r.wbCount == 2'(WB_DEPTH)
      && !(r.memReq.valid && r.memReq.write && memRsp.ack) |=> !r.lsRsp.ack) // R26
    else $error("store accepted into a full write buffer");
  drain_first_a: assert property (r.memReq.valid && !r.memReq.write |-> r.wbCount == 2'd0) // R4
    else $error("fill read issued with buffered writes pending");
  diag_refuse_a: assert property (r.state == ST_IDLE && lsReq.valid && lsReq.alt
      && lsReq.asi[3:2] == 2'b11 && r.flushing && !r.lsRsp.ack
      |=> r.lsRsp.ack && r.lsRsp.trap && r.lsRsp.trapType == 8'h09) // R22
    else $error("diagnostic access during flush not trapped");
  write_err_a: assert property (r.memReq.valid && r.memReq.write && memRsp.ack && memRsp.err
      |=> writeErrTrap ##1 !writeErrTrap) // R14
    else $error("write error trap not a single pulse");
  lane_copy_a: assert property (r.memReq.valid && r.memReq.write && r.memReq.be == 4'h8
      |-> r.memReq.wdata[31:24] == r.memReq.wdata[7:0]) // R3
    else $error("byte store not replicated");
  load_err_a: assert property (r.state == ST_READ && memRsp.ack && memRsp.err
      |=> r.lsRsp.ack && r.lsRsp.trap && r.lsRsp.trapType == 8'h09) // R12
    else $error("load error without trap 0x09");
  snoop_clear_a: assert property (snoopHit[0] |=> validArr[0][$past(snpIdx)] == 4'h0) // R10
    else $error("snooped line still valid");
endmodule

// File: tb/dcs_mem_model.sv
module dcs_mem_model
  import dcs_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire dcs_mem_req_t req,
  input  wire logic [7:0]   delay,
  input  wire logic         errOn,
  output      dcs_mem_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] mem [logic [29:0]];
  logic [7:0]  cnt;
  logic [31:0] cur;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp <= '0;
      cnt <= 8'h00;
    end else if (rsp.ack || !req.valid) begin
      // Idle read data is scrambled so a stale word never passes for an answer.
      rsp <= '{1'b0, 1'b0, ~rsp.rdata};
      cnt <= 8'h00;
    end else if (cnt >= delay) begin
      cur = mem.exists(req.addr[31:2]) ? mem[req.addr[31:2]] : ~{req.addr[31:2], 2'b00};
      if (req.write) begin
        for (int i = 0; i < 4; i++) begin
          if (req.be[3-i]) begin
            cur[31-8*i -: 8] = req.wdata[31-8*i -: 8];
          end
        end
        // A failed write leaves the old word in place.
        if (!errOn) begin
          mem[req.addr[31:2]] = cur;
        end
      end
      rsp <= '{1'b1, errOn, req.write ? ~rsp.rdata : cur};
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// File: tb/tb.sv
module tb
  import dcs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A = 32'h4000_0040;
  localparam logic [31:0] B = 32'h4000_0500;
  localparam logic [31:0] C = 32'h4000_0600;
  localparam logic [31:0] D = 32'h4000_0800;
  localparam logic [31:0] E = 32'h0000_0100;

  logic         ref_clk            = 1'b0;
  logic         sys_rst            = 1'b1;
  dcs_ls_req_t  lsReq              = '0;
  dcs_ls_rsp_t  lsRsp;
  logic         flushInsn          = 1'b0;
  logic         dcacheFlushRequest = 1'b0;
  logic [1:0]   dcacheStateField   = 2'h3;
  logic         snoopEnableBit     = 1'b1;
  logic         flushPending;
  logic         writeErrTrap;
  dcs_mem_req_t memReq;
  dcs_mem_rsp_t memRsp;
  dcs_snoop_t   snoop              = '0;
  dcs_ic_diag_t icReq;
  dcs_mem_rsp_t icRsp;
  dcs_mem_req_t icAsMem;
  logic         icFlush;
  logic [7:0]   memDelay           = 8'h02;
  logic         memErr             = 1'b0;
  logic         icSel;
  int           fails              = 0;
  int           num_checks         = 0;
  int           nReads             = 0;
  int           nWr                = 0;
  int           wrAtRead           = 0;
  int           nWe                = 0;
  int           cyc                = 0;
  int           nIcf               = 0;
  int           lat;
  dcs_ls_rsp_t  rsp;
  dcs_mem_req_t wq[$];

  dcs_data_cache dcs_data_cache_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .lsReq(lsReq), .lsRsp(lsRsp),
    .flushInsn(flushInsn), .dcacheFlushRequest(dcacheFlushRequest),
    .dcacheStateField(dcacheStateField), .snoopEnableBit(snoopEnableBit),
    .flushPending(flushPending), .writeErrTrap(writeErrTrap), .memReq(memReq),
    .memRsp(memRsp), .snoop(snoop), .icReq(icReq), .icRsp(icRsp), .icFlush(icFlush)
  );
  dcs_mem_model dcs_mem_model_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req(memReq), .delay(memDelay),
    .errOn(memErr), .rsp(memRsp)
  );
  dcs_mem_model dcs_ic_model_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req(icAsMem), .delay(8'h01),
    .errOn(1'b0), .rsp(icRsp)
  );

  assign icAsMem = '{icReq.valid, icReq.write, 4'hf, icReq.addr, icReq.wdata};

  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (writeErrTrap === 1'b1) begin
      nWe <= nWe + 1;
    end
    if (icFlush === 1'b1) begin
      nIcf <= nIcf + 1;
    end
    if (icReq.valid === 1'b1 && icRsp.ack === 1'b1) begin
      icSel <= icReq.dataSel;
    end
    if (memReq.valid === 1'b1 && memRsp.ack === 1'b1) begin
      if (memReq.write) begin
        nWr <= nWr + 1;
        wq.push_back(memReq);
      end else begin
        nReads <= nReads + 1;
        wrAtRead <= nWr;
      end
    end
  end

  function automatic logic [31:0] pat(input logic [31:0] a);
    return ~{a[31:2], 2'b00};
  endfunction

  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  // The request stays up until the edge that samples the answer, then drops.
  task automatic acc(input logic w, input logic al, input logic [7:0] asi,
                     input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
    lsReq <= '{1'b1, w, al, asi, sz, a, d};
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (lsRsp.ack !== 1'b1 && lat < 3000);
    rsp = lsRsp;
    lsReq.valid <= 1'b0;
    chk(lat < 3000, "no answer");
    @(posedge ref_clk);
  endtask

  task automatic ld(input logic [31:0] a, input int rd, input logic [31:0] d,
                    input logic al = 1'b0, input logic [7:0] asi = 8'h0b);
    int r0;
    r0 = nReads;
    acc(1'b0, al, asi, 2'h2, a, 32'h0);
    chk(nReads - r0 == rd, "memory read count");
    chk(rsp.rdata === d && rsp.trap === 1'b0, "load data");
  endtask

  task automatic waitFl();
    int k;
    k = 0;
    while (flushPending === 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < 3000, "flush hangs");
  endtask

  task automatic t_buffer();
    int w0;
    memDelay <= 8'h14;
    w0 = nWr;
    acc(1'b1, 1'b0, 8'h0b, 2'h0, 32'h4000_0301, 32'h0000_00ab);
    chk(lat <= 2, "byte store stalled");
    acc(1'b1, 1'b0, 8'h0b, 2'h1, 32'h4000_0306, 32'h0000_1234);
    chk(lat <= 2, "half store stalled");
    acc(1'b1, 1'b0, 8'h0b, 2'h2, 32'h4000_0308, 32'h1122_3344);
    chk(lat <= 2, "word store stalled");
    acc(1'b1, 1'b0, 8'h0b, 2'h2, 32'h4000_030c, 32'h5566_7788);
    chk(lat > 4, "fourth store not held");
    ld(32'h4000_0400, 1, pat(32'h4000_0400));
    chk(wrAtRead - w0 == 4, "fill before drain");
    chk(wq[w0].wdata === 32'habab_abab && wq[w0].be === 4'b0100, "byte lanes");
    chk(wq[w0+1].wdata === 32'h1234_1234 && wq[w0+1].be === 4'b0011, "half lanes");
    memDelay <= 8'h02;
  endtask

  task automatic t_hit();
    ld(A, 1, pat(A));
    ld(A, 0, pat(A));
    acc(1'b1, 1'b0, 8'h0b, 2'h2, A, 32'h0bad_f00d);
    ld(A, 0, 32'h0bad_f00d);
    acc(1'b1, 1'b0, 8'h0b, 2'h2, B, 32'h600d_cafe);
    ld(B, 1, 32'h600d_cafe);
    chk(wq[nWr-2].addr === A && wq[nWr-2].wdata === 32'h0bad_f00d, "hit not written");
    dcacheStateField <= 2'h1;
    ld(A, 0, 32'h0bad_f00d);
    ld(C, 1, pat(C));
    ld(C, 1, pat(C));
    dcacheStateField <= 2'h3;
  endtask

  task automatic t_err();
    int w0;
    int k;
    memErr <= 1'b1;
    acc(1'b0, 1'b0, 8'h0b, 2'h2, D, 32'h0);
    chk(rsp.trap === 1'b1 && rsp.trapType === 8'h09, "load error trap");
    memErr <= 1'b0;
    ld(D, 0, pat(D));
    w0 = nWe;
    k = 0;
    memErr <= 1'b1;
    acc(1'b1, 1'b0, 8'h0b, 2'h2, 32'h4000_0700, 32'h0000_0001);
    chk(rsp.trap === 1'b0, "store trapped at once");
    while (nWe == w0 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    memErr <= 1'b0;
    chk(nWe - w0 == 1, "write error trap");
  endtask

  task automatic t_snoop();
    for (int m = 0; m < 5; m++) begin
      acc(1'b0, 1'b0, 8'h0b, 2'h2, A, 32'h0);
      snoopEnableBit <= (m != 4);
      snoop <= '{1'b1, 2'(m), A};
      @(posedge ref_clk);
      snoop.valid <= 1'b0;
      ld(A, (m < 3) ? 1 : 0, 32'h0bad_f00d);
    end
    snoopEnableBit <= 1'b1;
  endtask

  task automatic t_flush();
    int c0;
    c0 = cyc;
    flushInsn <= 1'b1;
    @(posedge ref_clk);
    flushInsn <= 1'b0;
    ld(A, 1, 32'h0bad_f00d);
    chk(lat < 10, "stalled during flush");
    acc(1'b1, 1'b1, 8'h0e, 2'h2, 32'h0000_0040, 32'h0);
    chk(rsp.trap === 1'b1 && rsp.trapType === 8'h09, "diag during flush");
    waitFl();
    chk(cyc - c0 >= 1025 && cyc - c0 <= 1027, "flush length");
    ld(A, 1, 32'h0bad_f00d);
    ld(A, 0, 32'h0bad_f00d);
    dcacheFlushRequest <= 1'b1;
    dcacheStateField <= 2'h0;
    @(posedge ref_clk);
    dcacheFlushRequest <= 1'b0;
    @(posedge ref_clk);
    chk(flushPending === 1'b1, "register flush");
    waitFl();
    ld(A, 1, 32'h0bad_f00d);
    ld(A, 1, 32'h0bad_f00d);
    dcacheStateField <= 2'h3;
  endtask

  task automatic t_asi();
    logic [3:0] k;
    int         f0;
    ld(A, 1, 32'h0bad_f00d);
    for (int i = 0; i < 10; i++) begin
      k = (i < 4) ? 4'(i) : (i == 4) ? 4'h4 : (i == 5) ? 4'h7 : 4'(i + 2);
      ld(A, (k < 4'h8) ? 1 : 0, 32'h0bad_f00d, 1'b1, {4'ha, k});
    end
    f0 = nIcf;
    acc(1'b0, 1'b1, 8'h45, 2'h2, A, 32'h0);
    chk(rsp.trap === 1'b0 && nIcf - f0 == 1, "icache flush pulse");
    acc(1'b0, 1'b1, 8'h46, 2'h2, A, 32'h0);
    chk(flushPending === 1'b1, "flush by identifier");
    waitFl();
  endtask

  task automatic t_diag();
    acc(1'b1, 1'b1, 8'h5e, 2'h2, 32'h0000_2040, 32'h4000_200f);
    acc(1'b0, 1'b1, 8'h5e, 2'h2, 32'h0000_2040, 32'h0);
    chk(rsp.rdata[31:13] === 19'h20001 && rsp.rdata[3:0] === 4'hf, "tag readback");
    acc(1'b1, 1'b1, 8'h5f, 2'h2, 32'h0000_2044, 32'hcafe_0001);
    ld(32'h4000_2044, 0, 32'hcafe_0001);
    acc(1'b0, 1'b1, 8'h5f, 2'h2, 32'h0000_2044, 32'h0);
    chk(rsp.rdata === 32'hcafe_0001, "data readback");
    acc(1'b0, 1'b1, 8'h3c, 2'h2, E, 32'h0);
    chk(icSel === 1'b0 && rsp.rdata === pat(E), "icache tag");
    acc(1'b0, 1'b1, 8'h3d, 2'h2, E, 32'h0);
    chk(icSel === 1'b1 && rsp.rdata === pat(E), "icache data");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk(flushPending === 1'b1, "no flush after reset");
    waitFl();
    t_buffer();
    t_hit();
    t_err();
    t_snoop();
    t_flush();
    t_asi();
    t_diag();
    stop_test();
  end

  // Whole run needs about 5000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
